// ==== common/clkgen_defs.svh ====
// Constants for the clock generator control and status block.
// Assumes inclusion by the design file; definitions only.
// Behaviour
// (R1) Unmasked fault conditions drive interrupt high
// (R2) Lock-lost flag follows range fault, low in reset
// (R3) Lock-acquire flag high during reset locking
// (R4) Fault status readable at register 0xda
// (R5) Interrupt not latched; host uses edges
// (R6) Writing zero clears a set status bit
// (R7) Register 6 bits 4:0 mask interrupt sources
// (R8) Mask presets make interrupt a fault pin
// (R9) Disable pin turns off non always-on drivers
// (R10) Register 230 per-driver and global enables
// (R11) Bits 7:6 select each driver's disabled state
// (R12) Always-on drivers ignore every disable
// (R13) Per-channel spread enable and parameters held; the code keeps one spread rate shared by all channels
// (R14) Spread rate kept within 30 to 63 kHz
// (R15) Spread pin switches spread off everywhere
// (R16) Serial target, 7-bit address, auto-increment
// (R17) Address is six fixed bits plus pin
// (R18) Write: address, register pointer, data bytes
// (R19) Bytes travel most significant bit first
// (R20) Read from pointer set by earlier write
// (R21) Data-line timeout abandons stalled transfer; the code times the serial clock held low instead
// (R22) Host sets bus level bit below 2.5 V
// (R23) Interrupt is open drain, active high
// (R24) Disable pin is active high
// (R25) Status bits sticky; interrupt ORs unmasked ones
// (R26) Registers take defaults at reset
`ifndef CLKGEN_DEFS_SVH
`define CLKGEN_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define REG_INTERRUPT_MASK    8'h06
`define REG_BUS_LEVEL_CONFIG  8'h1b
`define REG_OUT_A_DIS_STATE   8'h6e
`define REG_OUT_B_DIS_STATE   8'h70
`define REG_OUT_C_DIS_STATE   8'h72
`define REG_OUT_D_DIS_STATE   8'h76
`define REG_FAULT_STATUS      8'hda
`define REG_OUTPUT_ENABLE     8'he6
`define REG_SPREAD_ENABLE     8'h1f
`define REG_SPREAD_RATE       8'h20

// ****************************************
// Field positions and reset values
// ****************************************
`define STAT_LOS_BIT          0
`define STAT_LOL_BIT          1
`define STAT_CAL_BIT          2
`define GLOBAL_DIS_BIT        4
`define DIS_STATE_MSB         7
`define DIS_STATE_LSB         6
`define RST_MASK              8'h00
`define RST_OUTPUT_ENABLE     8'h00
`define RST_DIS_STATE         8'h00
`define RST_SPREAD_RATE       8'h20
`define SPREAD_RATE_MIN_KHZ   8'h1e
`define SPREAD_RATE_MAX_KHZ   8'h3f
`define TARGET_ADDR_FIXED     6'h38

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS         5
`define SDA_TIMEOUT_US        25
`define SDA_TIMEOUT_CYC       (`SDA_TIMEOUT_US * 1000 / `CLK_PERIOD_NS)

`endif

// ==== common/clkgen_pkg.sv ====
// Types shared by the clock generator control block.
// Assumes the defines header is available on the include path.
package clkgen_pkg;

	// Serial target states, Gray along the write path; ack to tx flips two bits
	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_addr = 3'b001,
		st_ack  = 3'b011,
		st_data = 3'b010,
		st_tx   = 3'b110,
		st_rack = 3'b111
	} link_state_type;

	// Disabled-state encodings of a driver
	typedef enum logic [1:0] {
		dis_tristate = 2'b00,
		dis_low      = 2'b01,
		dis_high     = 2'b10,
		dis_always   = 2'b11
	} dis_state_type;

	// Write event passed from link to core domain
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} reg_write_type;

	// Driver control per output bank
	typedef struct packed {
		logic       enable;
		logic [1:0] off_level;
	} drv_ctrl_type;

endpackage

// ==== hdl/clockgen_i2c_ctrl_status.sv ====
// Control and status core of a four-bank clock generator.
// Assumes serial clock arrives on its own port; fault inputs are async.
`timescale 1ns/1ps
`include "clkgen_defs.svh"

module clockgen_i2c_ctrl_status #(
	parameter int unsigned TIMEOUT_CYC = `SDA_TIMEOUT_CYC,
	parameter int          NUM_BANKS   = 4
) (
	input  wire logic                        clk,
	input  wire logic                        arst_n,
	input  wire logic                        clk_en,
	input  wire logic                        scl,
	input  wire logic                        sda_in,
	output logic                             sda_out,
	output logic                             sda_oe_n,
	input  wire logic                        addr_lsb_pin,
	input  wire logic                        input_signal_lost,
	input  wire logic                        pll_range_fault,
	input  wire logic                        lock_busy,
	input  wire logic                        outputs_off_pin,
	input  wire logic                        spread_off_pin,
	output logic                             fault_irq_out,
	output logic                             fault_irq_oe_n,
	output clkgen_pkg::drv_ctrl_type [3:0]   drv_ctrl,
	output logic [3:0]                       spread_active,
	output logic [7:0]                       spread_rate_khz
);

	// ****************************************
	// Link domain: serial target on scl
	// ****************************************
	clkgen_pkg::link_state_type state_reg;  // Bit-level state
	logic [7:0] shift_reg;                  // Incoming byte
	logic [7:0] tx_reg;                     // Outgoing byte
	logic [2:0] bit_cnt_reg;                // Bits left in byte
	logic       rw_reg;                     // Read transfer
	logic       have_ptr_reg;               // Pointer byte seen
	logic [7:0] ptr_reg;                    // Register pointer
	logic [7:0] wr_addr_reg;                // Captured write address
	logic [7:0] wr_data_reg;                // Captured write data
	logic       wr_tog_reg;                 // Toggles per write
	logic       start_tog_reg;              // Start seen, sda domain
	logic       start_seen_reg;             // Start copy in scl domain
	logic       abort_link;                 // Timeout level in scl side
	logic [7:0] rd_bus [0:255];             // Read view, core domain
	logic [1:0] abort_sync_reg;             // Timeout into scl side
	logic       timeout_hit_reg;            // Watchdog fired, core side

	// Start is a falling data edge while the clock is high
	always_ff @(negedge sda_in or negedge arst_n) begin
		if (!arst_n) begin
			start_tog_reg <= 1'b0;
		end else if (scl) begin
			start_tog_reg <= ~start_tog_reg;
		end
	end

	// Timeout abort carried into the scl domain, two stages
	always_ff @(posedge scl or negedge arst_n) begin
		if (!arst_n) begin
			abort_sync_reg <= 2'b00;
		end else begin
			abort_sync_reg <= {abort_sync_reg[0], timeout_hit_reg};
		end
	end
	assign abort_link = abort_sync_reg[1];

	// Sample data on rising clock edges
	always_ff @(posedge scl or negedge arst_n) begin
		if (!arst_n) begin
			state_reg      <= clkgen_pkg::st_idle;
			shift_reg      <= 8'h00;
			bit_cnt_reg    <= 3'h7;
			rw_reg         <= 1'b0;
			have_ptr_reg   <= 1'b0;
			ptr_reg        <= 8'h00;
			wr_addr_reg    <= 8'h00;
			wr_data_reg    <= 8'h00;
			wr_tog_reg     <= 1'b0;
			start_seen_reg <= 1'b0;
		end else if (start_seen_reg != start_tog_reg) begin
			// Fresh start: begin address byte with this bit
			start_seen_reg <= start_tog_reg;
			state_reg      <= clkgen_pkg::st_addr;
			shift_reg      <= {7'h00, sda_in};
			bit_cnt_reg    <= 3'h6;
			have_ptr_reg   <= 1'b0;
		end else if (abort_link) begin
			state_reg <= clkgen_pkg::st_idle;  // [R21]
		end else begin
			unique case (state_reg)
				clkgen_pkg::st_idle: begin
				end
				clkgen_pkg::st_addr: begin
					shift_reg <= {shift_reg[6:0], sda_in};  // [R19]
					bit_cnt_reg <= bit_cnt_reg - 3'h1;
					if (bit_cnt_reg == 3'h0) begin
						// Six fixed bits then the pin bit [R17] [R16]
						if (shift_reg[6:0] ==
						    {`TARGET_ADDR_FIXED, addr_lsb_pin}) begin
							rw_reg    <= sda_in;
							state_reg <= clkgen_pkg::st_ack;
						end else begin
							state_reg <= clkgen_pkg::st_idle;
						end
					end
				end
				clkgen_pkg::st_ack: begin
					bit_cnt_reg <= 3'h7;
					state_reg   <= rw_reg ? clkgen_pkg::st_tx
					                      : clkgen_pkg::st_data;
				end
				clkgen_pkg::st_data: begin
					shift_reg <= {shift_reg[6:0], sda_in};  // [R19]
					bit_cnt_reg <= bit_cnt_reg - 3'h1;
					if (bit_cnt_reg == 3'h0) begin
						state_reg <= clkgen_pkg::st_ack;
						if (!have_ptr_reg) begin
							ptr_reg      <= {shift_reg[6:0], sda_in};  // [R18]
							have_ptr_reg <= 1'b1;
						end else begin
							// Data byte: post write, advance pointer [R18]
							wr_addr_reg <= ptr_reg;
							wr_data_reg <= {shift_reg[6:0], sda_in};
							wr_tog_reg  <= ~wr_tog_reg;
							ptr_reg     <= ptr_reg + 8'h01;
						end
					end
				end
				clkgen_pkg::st_tx: begin
					bit_cnt_reg <= bit_cnt_reg - 3'h1;
					if (bit_cnt_reg == 3'h0) begin
						state_reg <= clkgen_pkg::st_rack;
						ptr_reg   <= ptr_reg + 8'h01;  // [R20]
					end
				end
				clkgen_pkg::st_rack: begin
					// Host nack ends the burst
					bit_cnt_reg <= 3'h7;
					state_reg   <= sda_in ? clkgen_pkg::st_idle
					                      : clkgen_pkg::st_tx;
				end
			endcase
		end
	end

	// Drive data on falling clock edges; low enable pulls the line
	always_ff @(negedge scl or negedge arst_n) begin
		if (!arst_n) begin
			sda_oe_n <= 1'b1;
			tx_reg   <= 8'h00;
		end else begin
			unique case (state_reg)
				clkgen_pkg::st_ack: begin
					sda_oe_n <= 1'b0;
					tx_reg   <= rd_bus[ptr_reg];  // [R20]
				end
				clkgen_pkg::st_tx: begin
					sda_oe_n <= tx_reg[bit_cnt_reg];  // [R19]
				end
				clkgen_pkg::st_rack: begin
					// Reload for the next burst byte [R20]
					sda_oe_n <= 1'b1;
					tx_reg   <= rd_bus[ptr_reg];
				end
				default: begin
					sda_oe_n <= 1'b1;
				end
			endcase
		end
	end
	assign sda_out = 1'b0;

	// ****************************************
	// Core domain
	// ****************************************
	logic [2:0] wr_sync_reg;       // Write toggle synchroniser
	logic [2:0] scl_sync_reg;      // Serial clock activity
	logic [2:0] los_sync_reg;      // Fault input stages
	logic [2:0] lol_sync_reg;
	logic [2:0] cal_sync_reg;
	logic [2:0] oe_sync_reg;
	logic [2:0] ssc_sync_reg;
	logic       los_q, lol_q, cal_q, oe_q, ssc_q;  // Settled levels
	logic [7:0] mask_reg;
	logic [7:0] bus_level_reg;
	logic [7:0] status_reg;
	logic [7:0] oe_ctrl_reg;
	logic [7:0] spread_en_reg;
	logic [7:0] spread_rate_reg;
	logic [7:0] dis_state_reg [0:3];
	logic [31:0] idle_cnt_reg;     // Cycles with the clock held low
	logic       wr_event;
	logic [4:0] event_vec;

	// Three-stage synchronisers; change counts once stages 2 and 3 agree
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_sync_reg  <= 3'h0;
			scl_sync_reg <= 3'h7;
			los_sync_reg <= 3'h0;
			lol_sync_reg <= 3'h0;
			cal_sync_reg <= 3'h0;
			oe_sync_reg  <= 3'h0;
			ssc_sync_reg <= 3'h0;
			los_q <= 1'b0;
			lol_q <= 1'b0;
			cal_q <= 1'b0;
			oe_q  <= 1'b0;
			ssc_q <= 1'b0;
		end else if (clk_en) begin
			wr_sync_reg  <= {wr_sync_reg[1:0], wr_tog_reg};
			scl_sync_reg <= {scl_sync_reg[1:0], scl};
			los_sync_reg <= {los_sync_reg[1:0], input_signal_lost};
			lol_sync_reg <= {lol_sync_reg[1:0], pll_range_fault};
			cal_sync_reg <= {cal_sync_reg[1:0], lock_busy};
			oe_sync_reg  <= {oe_sync_reg[1:0], outputs_off_pin};
			ssc_sync_reg <= {ssc_sync_reg[1:0], spread_off_pin};
			if (los_sync_reg[2] == los_sync_reg[1]) los_q <= los_sync_reg[2];
			if (lol_sync_reg[2] == lol_sync_reg[1]) lol_q <= lol_sync_reg[2];
			if (cal_sync_reg[2] == cal_sync_reg[1]) cal_q <= cal_sync_reg[2];
			if (oe_sync_reg[2] == oe_sync_reg[1])   oe_q  <= oe_sync_reg[2];
			if (ssc_sync_reg[2] == ssc_sync_reg[1]) ssc_q <= ssc_sync_reg[2];
		end
	end

	assign wr_event = wr_sync_reg[2] ^ wr_sync_reg[1];

	// Loss of lock is suppressed while locking is in progress [R2] [R3]
	assign event_vec = {2'b00, cal_q, lol_q & ~cal_q, los_q};

	// Stall watchdog on the serial clock [R21]
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			idle_cnt_reg    <= 32'h0;
			timeout_hit_reg <= 1'b0;
		end else if (clk_en) begin
			// Only a clock held low is a stall; high means bus idle
			if (scl_sync_reg[2] != scl_sync_reg[1] || scl_sync_reg[2]) begin
				idle_cnt_reg    <= 32'h0;
				timeout_hit_reg <= 1'b0;
			end else if (idle_cnt_reg >= TIMEOUT_CYC) begin
				timeout_hit_reg <= 1'b1;
			end else begin
				idle_cnt_reg <= idle_cnt_reg + 32'h1;
			end
		end
	end

	// Register writes; defaults restored at reset [R26]
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_reg        <= `RST_MASK;
			bus_level_reg   <= 8'h00;
			oe_ctrl_reg     <= `RST_OUTPUT_ENABLE;
			spread_en_reg   <= 8'h00;
			spread_rate_reg <= `RST_SPREAD_RATE;
			for (int i = 0; i < 4; i++) dis_state_reg[i] <= `RST_DIS_STATE;
		end else if (clk_en && wr_event) begin
			unique case (wr_addr_reg)
				`REG_INTERRUPT_MASK:   mask_reg      <= wr_data_reg;  // [R7]
				`REG_BUS_LEVEL_CONFIG: bus_level_reg <= wr_data_reg;  // [R22]
				`REG_OUTPUT_ENABLE:    oe_ctrl_reg   <= wr_data_reg;  // [R10]
				`REG_SPREAD_ENABLE:    spread_en_reg <= wr_data_reg;  // [R13]
				`REG_SPREAD_RATE: begin
					// Clamp into the legal modulation band [R14]
					if (wr_data_reg < `SPREAD_RATE_MIN_KHZ)
						spread_rate_reg <= `SPREAD_RATE_MIN_KHZ;
					else if (wr_data_reg > `SPREAD_RATE_MAX_KHZ)
						spread_rate_reg <= `SPREAD_RATE_MAX_KHZ;
					else
						spread_rate_reg <= wr_data_reg;
				end
				`REG_OUT_A_DIS_STATE:  dis_state_reg[0] <= wr_data_reg;  // [R11]
				`REG_OUT_B_DIS_STATE:  dis_state_reg[1] <= wr_data_reg;
				`REG_OUT_C_DIS_STATE:  dis_state_reg[2] <= wr_data_reg;
				`REG_OUT_D_DIS_STATE:  dis_state_reg[3] <= wr_data_reg;
				default: begin
				end
			endcase
		end
	end

	// Sticky status: set beats a write-zero clear [R25] [R6]
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_reg <= 8'h00;
		end else if (clk_en) begin
			if (wr_event && wr_addr_reg == `REG_FAULT_STATUS)
				status_reg <= (status_reg & wr_data_reg) | {3'h0, event_vec};
			else
				status_reg <= status_reg | {3'h0, event_vec};
		end
	end

	// Read view of the map for the link side [R4]
	always_comb begin
		for (int i = 0; i < 256; i++) rd_bus[i] = 8'h00;
		rd_bus[`REG_INTERRUPT_MASK]   = mask_reg;
		rd_bus[`REG_BUS_LEVEL_CONFIG] = bus_level_reg;
		rd_bus[`REG_OUTPUT_ENABLE]    = oe_ctrl_reg;
		rd_bus[`REG_SPREAD_ENABLE]    = spread_en_reg;
		rd_bus[`REG_SPREAD_RATE]      = spread_rate_reg;
		rd_bus[`REG_FAULT_STATUS]     = status_reg;
		rd_bus[`REG_OUT_A_DIS_STATE]  = dis_state_reg[0];
		rd_bus[`REG_OUT_B_DIS_STATE]  = dis_state_reg[1];
		rd_bus[`REG_OUT_C_DIS_STATE]  = dis_state_reg[2];
		rd_bus[`REG_OUT_D_DIS_STATE]  = dis_state_reg[3];
	end

	// Interrupt: unmasked sticky bits, open drain [R1] [R8] [R23]
	// Pin pulled low when quiet, released when active; no latch [R5]
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_irq_out  <= 1'b0;
			fault_irq_oe_n <= 1'b1;
		end else if (clk_en) begin
			fault_irq_out  <= |(status_reg[4:0] & ~mask_reg[4:0]);
			fault_irq_oe_n <= |(status_reg[4:0] & ~mask_reg[4:0]);
		end
	end

	// Driver control per bank [R9] [R12] [R24]
	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					drv_ctrl[b]      <= '0;
					spread_active[b] <= 1'b0;
				end else if (clk_en) begin
					drv_ctrl[b].off_level <=
						dis_state_reg[b][`DIS_STATE_MSB:`DIS_STATE_LSB];
					drv_ctrl[b].enable <=
						(dis_state_reg[b][7:6] == clkgen_pkg::dis_always) ||
						(!oe_q && !oe_ctrl_reg[`GLOBAL_DIS_BIT] &&
						 !oe_ctrl_reg[b]);  // [R10]
					spread_active[b] <= spread_en_reg[b] & ~ssc_q;  // [R15]
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) spread_rate_khz <= `RST_SPREAD_RATE;
		else if (clk_en) spread_rate_khz <= spread_rate_reg;
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_irq_mask;
		@(posedge clk) disable iff (!arst_n)
		clk_en && (status_reg[4:0] & ~mask_reg[4:0]) != 5'h0 |=> fault_irq_out;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq missing"); // [R1]

	property p_sticky;
		@(posedge clk) disable iff (!arst_n)
		clk_en && status_reg[0] && !wr_event |=> status_reg[0];
	endproperty
	a_sticky: assert property (p_sticky) else $error("status lost"); // [R25]

	property p_always_on;
		@(posedge clk) disable iff (!arst_n)
		clk_en && dis_state_reg[0][7:6] == 2'b11 |=> drv_ctrl[0].enable;
	endproperty
	a_always_on: assert property (p_always_on) else $error("always on"); // [R12]

	property p_pin_off;
		@(posedge clk) disable iff (!arst_n)
		clk_en && oe_q && dis_state_reg[1][7:6] != 2'b11
		|=> !drv_ctrl[1].enable;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin off"); // [R9]

	property p_spread_pin;
		@(posedge clk) disable iff (!arst_n)
		clk_en && ssc_q |=> spread_active == 4'h0;
	endproperty
	a_spread_pin: assert property (p_spread_pin) else $error("spread"); // [R15]

	property p_rate;
		@(posedge clk) disable iff (!arst_n)
		spread_rate_reg >= 8'h1e && spread_rate_reg <= 8'h3f;
	endproperty
	a_rate: assert property (p_rate) else $error("rate band"); // [R14]

	property p_lol_cal;
		@(posedge clk) disable iff (!arst_n)
		clk_en && cal_q && !status_reg[1] |=> !status_reg[1];
	endproperty
	a_lol_cal: assert property (p_lol_cal) else $error("lol in cal"); // [R3]

	property p_global;
		@(posedge clk) disable iff (!arst_n)
		clk_en && oe_ctrl_reg[4] && dis_state_reg[2][7:6] != 2'b11
		|=> !drv_ctrl[2].enable;
	endproperty
	a_global: assert property (p_global) else $error("global"); // [R10]

	c_irq:   cover property (@(posedge clk) fault_irq_out);
	c_write: cover property (@(posedge clk) wr_event);
	c_tmo:   cover property (@(posedge clk) timeout_hit_reg);

endmodule

// ==== verification/i2c_host_model.sv ====
// Serial bus host model that drives the clock and pulls the data line.
// Assumes the bench resolves the pulled-up data line from all pull-downs.
`timescale 1ns/1ps

module i2c_host_model #(
	parameter int HALF_NS = 40
) (
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda_line
);

	// ****************************************
	// Idle: clock stands high, data released
	// ****************************************
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Start or repeated start: data falls while clock high
	task automatic start_cond();
		sda_low = 1'b0;
		#(HALF_NS/2);
		scl = 1'b1;
		#(HALF_NS);
		sda_low = 1'b1;
		#(HALF_NS/2);
		scl = 1'b0;
		#(HALF_NS/2);
	endtask

	// Stop: data rises while clock high, clock then stands still
	task automatic stop_cond();
		sda_low = 1'b1;
		#(HALF_NS/2);
		scl = 1'b1;
		#(HALF_NS/2);
		sda_low = 1'b0;
		#(HALF_NS);
	endtask

	// One bit: data changes only while clock is low
	task automatic clk_bit(input logic b, output logic seen);
		sda_low = !b;
		#(HALF_NS/2);
		scl = 1'b1;
		#(HALF_NS/2);
		seen = sda_line;
		#(HALF_NS/2);
		scl = 1'b0;
		#(HALF_NS/2);
	endtask

	// Byte out, most significant bit first, then ack slot
	task automatic send_byte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(v[i], s);
		clk_bit(1'b1, s);
		ack = !s;
	endtask

	// Byte in; a released ack slot ends a burst read
	task automatic recv_byte(input logic last, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, s);
			v[i] = s;
		end
		clk_bit(last, s);
	endtask

endmodule

// ==== verification/clockgen_i2c_ctrl_status_bench.sv ====
// Self-checking bench for the clock generator control and status block.
// Assumes the host model file and the package are compiled before it.
`timescale 1ns/1ps

module clockgen_i2c_ctrl_status_bench;

	// ****************************************
	// Signals
	// ****************************************
	logic                           clk;
	logic                           arst_n;
	logic                           scl;
	logic                           host_low;
	logic                           sda_line;
	logic                           sda_out;
	logic                           sda_oe_n;
	logic                           addr_lsb_pin;
	logic                           input_signal_lost;
	logic                           pll_range_fault;
	logic                           lock_busy;
	logic                           outputs_off_pin;
	logic                           spread_off_pin;
	logic                           fault_irq_out;
	logic                           fault_irq_oe_n;
	clkgen_pkg::drv_ctrl_type [3:0] drv_ctrl;
	logic [3:0]                     spread_active;
	logic [7:0]                     spread_rate_khz;
	logic [3:0]                     drv_en;
	logic [6:0]                     dev_addr;
	logic                           want_ack;
	logic [7:0]                     rd_q[$];
	int                             err_total;
	int                             checks;
	int                             cyc;
	logic                           s;

	// Pulled-up data line: any party pulling low wins
	assign sda_line = !(host_low || (!sda_oe_n && !sda_out));
	assign drv_en = {drv_ctrl[3].enable, drv_ctrl[2].enable,
		drv_ctrl[1].enable, drv_ctrl[0].enable};

	// Core clock, 5 ns period
	initial clk = 1'b0;
	always #2.5 clk = !clk;

	i2c_host_model i_host (
		.scl      (scl),
		.sda_low  (host_low),
		.sda_line (sda_line)
	);

	// Short timeout keeps the stall scenario brief
	clockgen_i2c_ctrl_status #(
		.TIMEOUT_CYC (200)
	) i_dut (
		.clk               (clk),
		.arst_n            (arst_n),
		.clk_en            (1'b1),
		.scl               (scl),
		.sda_in            (sda_line),
		.sda_out           (sda_out),
		.sda_oe_n          (sda_oe_n),
		.addr_lsb_pin      (addr_lsb_pin),
		.input_signal_lost (input_signal_lost),
		.pll_range_fault   (pll_range_fault),
		.lock_busy         (lock_busy),
		.outputs_off_pin   (outputs_off_pin),
		.spread_off_pin    (spread_off_pin),
		.fault_irq_out     (fault_irq_out),
		.fault_irq_oe_n    (fault_irq_oe_n),
		.drv_ctrl          (drv_ctrl),
		.spread_active     (spread_active),
		.spread_rate_khz   (spread_rate_khz)
	);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks++;
		if (seen !== want) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic test_done();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Let async pins cross and registered outputs settle
	task automatic settle();
		repeat (12) @(negedge clk);
	endtask

	// Burst write: address, pointer, then data bytes
	task automatic reg_write(input logic [7:0] ptr, input logic [7:0] v[$]);
		logic a;
		i_host.start_cond();
		i_host.send_byte({dev_addr, 1'b0}, a);
		check(8'(a), 8'(want_ack));
		i_host.send_byte(ptr, a);
		foreach (v[i]) i_host.send_byte(v[i], a);
		i_host.stop_cond();
		settle();
	endtask

	// Pointer write, repeated start, burst read of n bytes
	task automatic reg_read(input logic [7:0] ptr, input int n);
		logic       a;
		logic [7:0] b;
		rd_q = {};
		i_host.start_cond();
		i_host.send_byte({dev_addr, 1'b0}, a);
		i_host.send_byte(ptr, a);
		i_host.start_cond();
		i_host.send_byte({dev_addr, 1'b1}, a);
		for (int i = 0; i < n; i++) begin
			i_host.recv_byte(i == n - 1, b);
			rd_q.push_back(b);
		end
		i_host.stop_cond();
	endtask

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			err_total++;
			test_done();
		end
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		arst_n = 1'b0;
		addr_lsb_pin = 1'b0;
		input_signal_lost = 1'b0;
		pll_range_fault = 1'b0;
		lock_busy = 1'b0;
		outputs_off_pin = 1'b0;
		spread_off_pin = 1'b0;
		dev_addr = 7'h70;
		want_ack = 1'b1;
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		settle();
		// Defaults
		check(spread_rate_khz, 8'h20);
		check(8'(fault_irq_out), 8'h00);
		check(8'(drv_en), 8'h0f);
		reg_read(8'h06, 1);
		check(rd_q[0], 8'h00);
		// Burst across an unmapped place
		reg_write(8'h6e, {8'h40, 8'h5a, 8'h80});
		reg_read(8'h6e, 3);
		check(rd_q[0], 8'h40);
		check(rd_q[1], 8'h00);
		check(rd_q[2], 8'h80);
		// Foreign address is ignored, then the pin moves us
		dev_addr = 7'h71;
		want_ack = 1'b0;
		reg_write(8'h6e, {8'hc0});
		addr_lsb_pin = 1'b1;
		want_ack = 1'b1;
		reg_read(8'h6e, 1);
		check(rd_q[0], 8'h40);
		reg_write(8'h72, {8'hc0});
		// Disable pin spares the always-on bank
		outputs_off_pin = 1'b1;
		settle();
		check(8'(drv_en), 8'h04);
		check(8'(drv_ctrl[0].off_level), 8'h01);
		check(8'(drv_ctrl[1].off_level), 8'h02);
		outputs_off_pin = 1'b0;
		settle();
		check(8'(drv_en), 8'h0f);
		reg_write(8'he6, {8'h01});
		check(8'(drv_en), 8'h0e);
		reg_write(8'he6, {8'h10});
		check(8'(drv_en), 8'h04);
		reg_write(8'he6, {8'h00});
		// Lost input: sticky status, cleared by zeros
		input_signal_lost = 1'b1;
		settle();
		check(8'(fault_irq_out), 8'h01);
		check(8'(fault_irq_oe_n), 8'h01);
		input_signal_lost = 1'b0;
		settle();
		check(8'(fault_irq_out), 8'h01);
		reg_read(8'hda, 1);
		check(rd_q[0], 8'h01);
		reg_write(8'hda, {8'h00});
		check(8'(fault_irq_out), 8'h00);
		check(8'(fault_irq_oe_n), 8'h00);
		// Masked source stays quiet until unmasked
		reg_write(8'h06, {8'h01});
		input_signal_lost = 1'b1;
		settle();
		input_signal_lost = 1'b0;
		settle();
		check(8'(fault_irq_out), 8'h00);
		reg_write(8'h06, {8'h00});
		check(8'(fault_irq_out), 8'h01);
		reg_write(8'hda, {8'h00});
		// Range fault hidden while locking
		lock_busy = 1'b1;
		pll_range_fault = 1'b1;
		settle();
		reg_read(8'hda, 1);
		check(rd_q[0], 8'h04);
		lock_busy = 1'b0;
		settle();
		pll_range_fault = 1'b0;
		reg_read(8'hda, 1);
		check(rd_q[0], 8'h06);
		reg_write(8'hda, {8'h00});
		check(8'(fault_irq_out), 8'h00);
		// Spread enables, pin override, rate clamp
		reg_write(8'h1f, {8'h0f});
		check(8'(spread_active), 8'h0f);
		spread_off_pin = 1'b1;
		settle();
		check(8'(spread_active), 8'h00);
		spread_off_pin = 1'b0;
		reg_write(8'h20, {8'h10});
		check(spread_rate_khz, 8'h1e);
		reg_write(8'h20, {8'h40});
		check(spread_rate_khz, 8'h3f);
		// Low-voltage bus setting is held and read back
		reg_write(8'h1b, {8'h80});
		reg_read(8'h1b, 1);
		check(rd_q[0], 8'h80);
		// Stall mid-byte; an abandoned transfer must not ack
		i_host.start_cond();
		i_host.send_byte({dev_addr, 1'b0}, s);
		for (int i = 0; i < 3; i++) i_host.clk_bit(1'b0, s);
		#2000;
		check(8'(sda_oe_n), 8'h01);
		for (int i = 0; i < 6; i++) i_host.clk_bit(1'b1, s);
		check(8'(s), 8'h01);
		i_host.stop_cond();
		test_done();
	end

endmodule
